// ==== hw/pcl_cfg.svh ====
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH
// ****************************************************************
// Control law constants
// ****************************************************************
// Controller span in tenths of a degree (415.0 degrees)
`define PCL_SPAN_TENTHS   16'h1036
// Full-scale percentage and windup fallback
`define PCL_FULL_PCT      8'h64
// Switch values seen before the first sampled pin value
`define PCL_RESET_RATE_RST 8'h20
`define PCL_DERIV_RST      8'h00
`define PCL_WINDUP_RST     8'h00
`define PCL_GAIN_RST       8'h00
// Derivative switch fields
`define PCL_DR_HEAT_LSB   0
`define PCL_DR_COOL_LSB   3
`define PCL_DR_DIAG_BIT   6
// Seconds per minute, seconds per tenth of a minute
`define PCL_SEC_PER_MIN   60
`define PCL_TENTH_SEC     6
`endif

// ==== hw/pcl_pkg.sv ====
package pcl_pkg;
  // Control sequencer, one-hot
  typedef enum logic [1:0] {
    PCL_ST_IDLE = 2'b01,
    PCL_ST_CALC = 2'b10
  } pcl_state_t;
  // Diagnostic display selection
  typedef enum logic [1:0] {
    PCL_DG_BAND   = 2'h0,
    PCL_DG_RESET  = 2'h1,
    PCL_DG_WINDUP = 2'h2,
    PCL_DG_DERIV  = 2'h3
  } pcl_diag_t;
endpackage : pcl_pkg

// ==== hw/pcl_core.sv ====
`timescale 1ns/1ps
`include "pcl_cfg.svh"
module pcl_core #(
  parameter int SAMPLE_HZ = 10
) (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              sample_i,
  input  wire logic signed [15:0] setpoint_i,
  input  wire logic signed [15:0] process_i,
  input  wire logic              heat_mode_i,
  input  wire logic [7:0]        heat_gain_switch_i,
  input  wire logic [7:0]        cool_gain_switch_i,
  input  wire logic [7:0]        heat_reset_rate_switch_i,
  input  wire logic [7:0]        cool_reset_rate_switch_i,
  input  wire logic [7:0]        heat_windup_limit_switch_i,
  input  wire logic [7:0]        cool_windup_limit_switch_i,
  input  wire logic [7:0]        derivative_rate_switch_i,
  input  wire pcl_pkg::pcl_diag_t diag_sel_i,
  output logic [6:0]             demand_o,
  output logic                   heat_param_led_o,
  output logic                   diag_en_o,
  output logic [15:0]            diag_value_o
);
  import pcl_pkg::*;

  localparam int ISCALE = 100 * `PCL_SEC_PER_MIN * SAMPLE_HZ;
  localparam int DSCALE = `PCL_TENTH_SEC * SAMPLE_HZ;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Out-of-range windup settings fall back to full band
  function automatic logic [7:0] wi_pct(input logic [7:0] sw);
    wi_pct = (sw == 8'h00 || sw > `PCL_FULL_PCT) ? `PCL_FULL_PCT : sw;
  endfunction : wi_pct

  // Gain zero also gives zero band: treated as on/off control
  function automatic logic [15:0] band_of(input logic [7:0] gain);
    band_of = (gain == 8'h00) ? 16'h0000 : 16'(`PCL_SPAN_TENTHS / gain);
  endfunction : band_of

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [56:0] pin_meta_q;
  logic [56:0] pin_sync_q;
  logic [56:0] pin_raw;
  logic [56:0] pin_rst;

  // Pin high means element open, which reads as a one
  assign pin_raw = {heat_mode_i, heat_gain_switch_i, cool_gain_switch_i,
                    heat_reset_rate_switch_i, cool_reset_rate_switch_i,
                    heat_windup_limit_switch_i, cool_windup_limit_switch_i,
                    derivative_rate_switch_i};
  assign pin_rst = {1'b1, `PCL_GAIN_RST, `PCL_GAIN_RST, `PCL_RESET_RATE_RST,
                    `PCL_RESET_RATE_RST, `PCL_WINDUP_RST, `PCL_WINDUP_RST,
                    `PCL_DERIV_RST};

  // Two flops on every pin; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_meta_q <= pin_rst;
      pin_sync_q <= pin_rst;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  logic       heat_s;
  logic [7:0] gain_s;
  logic [7:0] rate_s;
  logic [7:0] wind_s;
  logic [7:0] drv_s;
  logic [2:0] td_s;

  // Active parameter set follows the mode pin
  always_comb begin
    heat_s = pin_sync_q[56];
    drv_s  = pin_sync_q[7:0];
    gain_s = heat_s ? pin_sync_q[55:48] : pin_sync_q[47:40];
    rate_s = heat_s ? pin_sync_q[39:32] : pin_sync_q[31:24];
    wind_s = heat_s ? pin_sync_q[23:16] : pin_sync_q[15:8];
    td_s   = heat_s ? drv_s[`PCL_DR_HEAT_LSB +: 3] : drv_s[`PCL_DR_COOL_LSB +: 3];
  end

  // ****************************************************************
  // Control computation
  // ****************************************************************
  pcl_state_t         st_q, st_d;
  logic signed [39:0] dev_q, dev_d;
  logic signed [39:0] dpv_q, dpv_d;
  logic signed [15:0] pv_prev_q, pv_prev_d;
  logic signed [39:0] acc_q, acc_d;
  logic [15:0]        band_q, band_d;
  logic [7:0]         rate_q, rate_d;
  logic [7:0]         wpct_q, wpct_d;
  logic [2:0]         td_q, td_d;
  logic [6:0]         dem_q, dem_d;

  logic signed [39:0] bnd;
  logic signed [39:0] den;
  logic signed [39:0] lim;
  logic signed [39:0] e_int;
  logic signed [39:0] p_t;
  logic signed [39:0] i_t;
  logic signed [39:0] d_t;
  logic signed [39:0] sum;
  logic               inband;
  logic               over;

  // Terms derived from the captured sample
  always_comb begin
    bnd    = signed'(40'(band_q));
    // Divide guard only; a zero band takes the on/off path below
    den    = (band_q == 16'h0000) ? 40'sh1 : bnd;
    lim    = (bnd * signed'(40'(wpct_q))) / 40'sh64;
    inband = ((dev_q < 0) ? -dev_q : dev_q) <= bnd;
    over   = -dev_q > lim;
    if (dev_q > lim) begin
      e_int = lim;
    end else if (dev_q < -lim) begin
      e_int = -lim;
    end else begin
      e_int = dev_q;
    end
  end

  // Accumulate, then sum the three independent terms
  always_comb begin
    st_d      = st_q;
    dev_d     = dev_q;
    dpv_d     = dpv_q;
    pv_prev_d = pv_prev_q;
    acc_d     = acc_q;
    band_d    = band_q;
    rate_d    = rate_q;
    wpct_d    = wpct_q;
    td_d      = td_q;
    dem_d     = dem_q;
    p_t       = '0;
    i_t       = '0;
    d_t       = '0;
    sum       = '0;
    unique case (st_q)
      PCL_ST_IDLE: begin
        if (sample_i) begin
          dev_d     = 40'(setpoint_i) - 40'(process_i);
          dpv_d     = 40'(process_i) - 40'(pv_prev_q);
          pv_prev_d = process_i;
          band_d    = band_of(gain_s);
          rate_d    = rate_s;
          wpct_d    = wi_pct(wind_s);
          td_d      = td_s;
          st_d      = PCL_ST_CALC;
        end
      end
      PCL_ST_CALC: begin
        if (over && acc_q > 0) begin
          acc_d = '0;
        end else if (inband && band_q != 16'h0000) begin
          acc_d = acc_q + e_int * signed'(40'(rate_q));
        end
        p_t = (dev_q * 40'sh64) / den;
        i_t = ((acc_d / ISCALE) * 40'sh64) / den;
        d_t = -(dpv_q * signed'(40'(td_q)) * DSCALE * 40'sh64) / den;
        sum = p_t + i_t + d_t;
        if (band_q == 16'h0000) begin
          dem_d = (dev_q > 0) ? 7'h64 : 7'h00;
        end else if (sum > 40'sh64) begin
          dem_d = 7'h64;
        end else if (sum < 0) begin
          dem_d = 7'h00;
        end else begin
          dem_d = sum[6:0];
        end
        st_d = PCL_ST_IDLE;
      end
    endcase
  end

  // Control state registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q      <= PCL_ST_IDLE;
      dev_q     <= '0;
      dpv_q     <= '0;
      pv_prev_q <= '0;
      acc_q     <= '0;
      band_q    <= '0;
      rate_q    <= '0;
      wpct_q    <= `PCL_FULL_PCT;
      td_q      <= '0;
      dem_q     <= '0;
    end else begin
      st_q      <= st_d;
      dev_q     <= dev_d;
      dpv_q     <= dpv_d;
      pv_prev_q <= pv_prev_d;
      acc_q     <= acc_d;
      band_q    <= band_d;
      rate_q    <= rate_d;
      wpct_q    <= wpct_d;
      td_q      <= td_d;
      dem_q     <= dem_d;
    end
  end

  // ****************************************************************
  // Indicator and diagnostics
  // ****************************************************************
  logic [15:0] diag_d;
  logic [15:0] diag_q;
  logic        led_q;
  logic        den_q;

  // Display value is live so switch edits show at once
  always_comb begin
    unique case (diag_sel_i)
      PCL_DG_BAND:   diag_d = band_of(gain_s);
      PCL_DG_RESET:  diag_d = {8'h00, rate_s};
      PCL_DG_WINDUP: diag_d = {8'h00, wi_pct(wind_s)};
      PCL_DG_DERIV:  diag_d = {13'h0000, td_s};
    endcase
  end

  // Output flops for indicator and display
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      led_q  <= 1'b0;
      den_q  <= 1'b0;
      diag_q <= '0;
    end else begin
      led_q  <= heat_s;
      den_q  <= drv_s[`PCL_DR_DIAG_BIT];
      diag_q <= diag_d;
    end
  end

  assign demand_o         = dem_q;
  assign heat_param_led_o = led_q;
  assign diag_en_o        = den_q;
  assign diag_value_o     = diag_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_take;
    st_q == PCL_ST_IDLE && sample_i;
  endsequence
  sequence s_calc_back;
    st_q == PCL_ST_CALC ##1 st_q == PCL_ST_IDLE;
  endsequence

  chk_cycle_order: assert property (s_take |=> s_calc_back)
    else $error("computation did not finish in two cycles");
  chk_int_hold_out: assert property (
    st_q == PCL_ST_CALC && !inband && !(over && acc_q > 0) |=> acc_q == $past(acc_q))
    else $error("integral moved outside the band");
  chk_wi_step: assert property (st_q == PCL_ST_CALC && !(over && acc_q > 0) |=>
    (acc_q - $past(acc_q) <= $past(lim) * signed'(40'($past(rate_q))))
    && ($past(acc_q) - acc_q <= $past(lim) * signed'(40'($past(rate_q)))))
    else $error("integral step exceeds windup limit");
  chk_wi_range: assert property (s_take |=> wpct_q >= 8'h01 && wpct_q <= 8'h64)
    else $error("windup percent out of range");
  chk_pv_steady: assert property (s_take ##0 (process_i == pv_prev_q) |=> dpv_q == 0)
    else $error("derivative input nonzero on steady process");
  chk_band_zero: assert property (st_q == PCL_ST_CALC && band_q == 16'h0000 |=>
    demand_o == (($past(dev_q) > 0) ? 7'h64 : 7'h00))
    else $error("zero band is not on/off");
  chk_clip_over: assert property (st_q == PCL_ST_CALC && over && acc_q > 0 |=> acc_q == 0)
    else $error("overshoot integral not clipped");
  chk_demand_sat: assert property (demand_o <= 7'h64)
    else $error("demand above full scale");
  chk_led_mode: assert property ($rose(heat_s) |=> heat_param_led_o)
    else $error("heat indicator not lit");
  chk_led_cool: assert property ($fell(heat_s) |=> !heat_param_led_o)
    else $error("heat indicator lit with cool set");
  chk_band_calc: assert property (s_take |=> band_q == band_of($past(gain_s)))
    else $error("bandwidth not span over gain");
endmodule : pcl_core

// ==== test/pcl_sensor.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Process sensor model
// ****************************************************************
module pcl_sensor (
  input  wire logic               clk_i,
  input  wire logic signed [15:0] target_i,
  output logic signed [15:0]      process_o
);
  // One conversion per clock; reading lags the plant by a cycle
  always_ff @(posedge clk_i) begin
    process_o <= target_i;
  end
endmodule : pcl_sensor

// ==== test/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
// ****************************************************************
// Control law bench
// ****************************************************************
module tb;
  import pcl_pkg::*;
  logic               clk, srst, smp, heat;
  logic signed [15:0] sp, tgt, pv;
  logic [7:0]         hg, cg, hr, cr, hw, cw, dr;
  pcl_diag_t          dsel;
  logic [6:0]         dem;
  logic               led, den;
  logic [15:0]        dval;
  int                 n_errors, num_checks, cyc;

  pcl_sensor u_pv (.clk_i(clk), .target_i(tgt), .process_o(pv));
  // Slow control rate keeps the derivative figures small and makes the integral figures large
  pcl_core #(.SAMPLE_HZ(1)) u_dut (
    .clk_i(clk), .srst_i(srst), .sample_i(smp), .setpoint_i(sp), .process_i(pv),
    .heat_mode_i(heat), .heat_gain_switch_i(hg), .cool_gain_switch_i(cg),
    .heat_reset_rate_switch_i(hr), .cool_reset_rate_switch_i(cr),
    .heat_windup_limit_switch_i(hw), .cool_windup_limit_switch_i(cw),
    .derivative_rate_switch_i(dr), .diag_sel_i(dsel), .demand_o(dem),
    .heat_param_led_o(led), .diag_en_o(den), .diag_value_o(dval));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // Reset also flushes the switch synchronisers
  task automatic rst_dut(input logic [7:0] g, r, w, d);
    @(posedge clk);
    #1 srst = 1'b1;
    hg = g;
    hr = r;
    hw = w;
    dr = d;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    // Two edges before the switch pins reach the control logic
    repeat (2) @(posedge clk);
    #1;
  endtask : rst_dut

  // One computation; every drive lands one step after an edge
  task automatic samp(input logic signed [15:0] s, p);
    @(posedge clk);
    #1 tgt = p;
    @(posedge clk);
    #1 sp = s;
    smp = 1'b1;
    @(posedge clk);
    #1 smp = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : samp

  task automatic t_prop();
    rst_dut(8'h45, 8'h00, 8'h00, 8'h00);
    samp(16'h03e8, 16'h03ca);
    `CHK(dem, 7'h32)
    `CHK(den, 1'b0)
    samp(16'h03e8, 16'h03e8);
    `CHK(dem, 7'h00)
    samp(16'h03e8, 16'h0370);
    `CHK(dem, 7'h64)
    samp(16'h03e8, 16'h0460);
    `CHK(dem, 7'h00)
    rst_dut(8'h00, 8'h00, 8'h00, 8'h00);
    samp(16'h03e8, 16'h03f2);
    `CHK(dem, 7'h00)
    samp(16'h03e8, 16'h03de);
    `CHK(dem, 7'h64)
  endtask : t_prop

  task automatic t_deriv();
    rst_dut(8'h45, 8'h00, 8'h00, 8'h01);
    samp(16'h03e8, 16'h03ca);
    samp(16'h03e8, 16'h03ca);
    `CHK(dem, 7'h32)
    samp(16'h03f2, 16'h03ca);
    `CHK(dem, 7'h42)
    samp(16'h03e8, 16'h03c9);
    `CHK(dem, 7'h3d)
    samp(16'h03e8, 16'h03c8);
    `CHK(dem, 7'h3f)
  endtask : t_deriv

  // Eight repeats of one error, then a zero-error readout of the integral
  task automatic t_integ(input logic [7:0] w, input logic signed [15:0] p,
                         input logic clip, input logic [6:0] exp_d);
    rst_dut(8'h45, 8'h80, w, 8'h00);
    repeat (8) samp(16'h03e8, p);
    // Overshoot past the band: without the clip the integral would just hold
    if (clip) samp(16'h03e8, 16'h042e);
    samp(16'h03e8, 16'h03e8);
    `CHK(dem, exp_d)
  endtask : t_integ

  task automatic t_mode();
    rst_dut(8'h45, 8'h80, 8'h00, 8'h4d);
    cg = 8'h00;
    heat = 1'b0;
    dsel = PCL_DG_BAND;
    repeat (4) @(posedge clk);
    samp(16'h03e8, 16'h03ca);
    `CHK(dem, 7'h64)
    `CHK(led, 1'b0)
    `CHK(dval, 16'h0000)
    dsel = PCL_DG_DERIV;
    @(posedge clk);
    #1 `CHK(dval, 16'h0001)
    dsel = PCL_DG_BAND;
    heat = 1'b1;
    repeat (4) @(posedge clk);
    samp(16'h03e8, 16'h03ca);
    `CHK(dem, 7'h32)
    `CHK(led, 1'b1)
    `CHK(dval, 16'h003c)
    `CHK(den, 1'b1)
    dsel = PCL_DG_WINDUP;
    @(posedge clk);
    #1 `CHK(dval, 16'h0064)
    dsel = PCL_DG_RESET;
    @(posedge clk);
    #1 `CHK(dval, 16'h0080)
    dsel = PCL_DG_DERIV;
    @(posedge clk);
    #1 `CHK(dval, 16'h0005)
  endtask : t_mode

  initial begin
    srst = 1'b1;
    smp = 1'b0;
    heat = 1'b1;
    sp = '0;
    tgt = '0;
    hg = '0;
    cg = '0;
    hr = '0;
    cr = '0;
    hw = '0;
    cw = '0;
    dr = '0;
    dsel = PCL_DG_BAND;
    n_errors = 0;
    num_checks = 0;
    // Power-on reset for two cycles, then each scenario resets again
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    t_prop();
    t_deriv();
    t_integ(8'h00, 16'h03ca, 1'b0, 7'h08);
    t_integ(8'hc8, 16'h03ca, 1'b0, 7'h08);
    t_integ(8'hc8, 16'h03ca, 1'b1, 7'h00);
    t_integ(8'h0a, 16'h03ca, 1'b0, 7'h01);
    t_integ(8'h00, 16'h03a2, 1'b0, 7'h00);
    t_integ(8'h0a, 16'h03ca, 1'b1, 7'h00);
    t_mode();
    finish_test();
  end

  // Hang guard, far above the expected run length
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 5000) begin
        n_errors++;
        finish_test();
      end
    end
  end
endmodule : tb
